// [src/pdm_clock_and_missing_clock_detect.sv]
// PDM clock configuration, divider power and missing-clock supervision
// Functional notes
// - PDM data latched on rising clock edge when edge bit 0, falling when 1.
// - PDM input clock pin is input when its direction bit 0, driven when 1.
// - PDM output clock pin is input when its direction bit 0, driven when 1.
// - PDM input clock divider runs only while its power bit is 1.
// - DSD clock divider is powered up only while its power bit is 1.
// - After fault restart, keep DSP memory if reload bit 0, reload defaults if 1.
// - Detector one watches serial audio clock when source bit 0, PDM clock when 1.
// - Detector two watches DAC modulator, ADC modulator or PLL clock; code 3 reserved.
// - Each detector works only while its enable bit is 1; bit 1 first, 0 second.
// - Three-bit timeout codes select 11 ms up to 1.2 s per detector.
// - Enabled detector seeing no clock for its timeout shuts the chip down.
// - Clock error sets sticky status bit; host clears it before powering up again.
`include "pdm_clk_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pdm_clock_and_missing_clock_detect
    import pdm_clk_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC_0 = `US_TO_CYC(`TIMEOUT_US_0),
    parameter int unsigned TIMEOUT_CYC_1 = `US_TO_CYC(`TIMEOUT_US_1),
    parameter int unsigned TIMEOUT_CYC_2 = `US_TO_CYC(`TIMEOUT_US_2),
    parameter int unsigned TIMEOUT_CYC_3 = `US_TO_CYC(`TIMEOUT_US_3),
    parameter int unsigned TIMEOUT_CYC_4 = `US_TO_CYC(`TIMEOUT_US_4),
    parameter int unsigned TIMEOUT_CYC_5 = `US_TO_CYC(`TIMEOUT_US_5),
    parameter int unsigned TIMEOUT_CYC_6 = `US_TO_CYC(`TIMEOUT_US_6),
    parameter int unsigned TIMEOUT_CYC_7 = `US_TO_CYC(`TIMEOUT_US_7)
) (
    input  wire logic              clk,
    input  wire logic              srst,
    // Control port
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire pdm_clk_pkg::reg_byte_t regAddr,
    input  wire pdm_clk_pkg::reg_byte_t regWdata,
    output var  pdm_clk_pkg::reg_byte_t regRdata_r,
    output var  logic              regRvalid_r,
    // PDM clock pins
    input  wire logic              densityInputClockIn,
    output var  logic              densityInputClockOut_r,
    output var  logic              densityInputClockOe_r,
    input  wire logic              densityOutputClockIn,
    output var  logic              densityOutputClockOut_r,
    output var  logic              densityOutputClockOe_r,
    input  wire logic              pdmData,
    output var  logic              pdmLatchedData_r,
    output var  logic              pdmLatchValid_r,
    // Watched clocks, sampled as levels
    input  wire logic              serialAudioClock,
    input  wire logic              dacModClock,
    input  wire logic              adcModClock,
    input  wire logic              pllClock,
    // Divider power, restart and shutdown
    output var  logic              densityDivRunning_r,
    output var  logic              bitstreamDivPowered_r,
    input  wire logic              faultRestart,
    output var  logic              dspMemReload_r,
    output var  logic              clockErrorShutdown_r
);
    import pdm_clk_pkg::*;

    localparam int NUM_DET = 2;

    reg_byte_t pulseDensityConfig_r;
    reg_byte_t pdmDividerControl_r;
    reg_byte_t dsdDividerControl_r;
    reg_byte_t clockErrorSourceEnable_r;
    reg_byte_t clockErrorTimeouts_r;
    reg_byte_t interruptPinConfig_r;
    logic      clockErrorStickyFlag_r;

    logic      densityDivClk_r;
    reg_byte_t densityDivCount_r;
    logic      pdmClockLevel;
    logic      pdmClockPrev_r;
    logic      pdmRise;
    logic      pdmFall;
    logic      anyExpired;
    logic      stickyClear;
    reg_byte_t regRdata_nxt;

    logic                pdmLatchEdgeSel;
    logic                pdmInClkDir;
    logic                pdmOutClkDir;
    logic                densityDivPower;
    logic                bitstreamDivPower;
    logic                dspMemReloadOnRestart;
    logic                detectorOneSource;
    detector_two_src_t   detectorTwoSource;
    logic                detectorOneEnable;
    logic                detectorTwoEnable;
    timeout_code_t       detectorOneTimeout;
    timeout_code_t       detectorTwoTimeout;

    assign pdmLatchEdgeSel       = pulseDensityConfig_r[`BIT_PDM_LATCH_EDGE_SEL];
    assign pdmInClkDir           = pulseDensityConfig_r[`BIT_DENSITY_INPUT_CLOCK_DIR];
    assign pdmOutClkDir          = pulseDensityConfig_r[`BIT_DENSITY_OUTPUT_CLOCK_DIR];
    assign densityDivPower       = pdmDividerControl_r[`BIT_DIV_POWER];
    assign bitstreamDivPower     = dsdDividerControl_r[`BIT_DIV_POWER];
    assign dspMemReloadOnRestart = clockErrorSourceEnable_r[`BIT_DSP_MEM_RELOAD];
    assign detectorOneSource     = clockErrorSourceEnable_r[`BIT_DETECTOR_ONE_SRC];
    assign detectorTwoSource     = detector_two_src_t'(
        clockErrorSourceEnable_r[`MSB_DETECTOR_TWO_SRC:`LSB_DETECTOR_TWO_SRC]);
    assign detectorOneEnable     = clockErrorSourceEnable_r[`BIT_DETECTOR_ONE_EN];
    assign detectorTwoEnable     = clockErrorSourceEnable_r[`BIT_DETECTOR_TWO_EN];
    assign detectorOneTimeout    = clockErrorTimeouts_r[`MSB_DETECTOR_ONE_TIME:`LSB_DETECTOR_ONE_TIME];
    assign detectorTwoTimeout    = clockErrorTimeouts_r[`MSB_DETECTOR_TWO_TIME:`LSB_DETECTOR_TWO_TIME];

    // Timeout code to clk cycles, shared by both detectors
    function automatic tick_count_t timeout_cycles(input timeout_code_t code);
        tick_count_t cyc;
        case (code)
            3'h0:    cyc = tick_count_t'(TIMEOUT_CYC_0);
            3'h1:    cyc = tick_count_t'(TIMEOUT_CYC_1);
            3'h2:    cyc = tick_count_t'(TIMEOUT_CYC_2);
            3'h3:    cyc = tick_count_t'(TIMEOUT_CYC_3);
            3'h4:    cyc = tick_count_t'(TIMEOUT_CYC_4);
            3'h5:    cyc = tick_count_t'(TIMEOUT_CYC_5);
            3'h6:    cyc = tick_count_t'(TIMEOUT_CYC_6);
            default: cyc = tick_count_t'(TIMEOUT_CYC_7);
        endcase
        return cyc;
    endfunction : timeout_cycles

    // Register writes
    always_ff @(posedge clk) begin
        if (srst) begin
            pulseDensityConfig_r     <= `RST_PULSE_DENSITY_CONFIG;
            pdmDividerControl_r      <= `RST_PDM_DIVIDER_CONTROL;
            dsdDividerControl_r      <= `RST_DSD_DIVIDER_CONTROL;
            clockErrorSourceEnable_r <= `RST_CLOCK_ERR_SRC_EN;
            clockErrorTimeouts_r     <= `RST_CLOCK_ERR_TIMEOUTS;
            interruptPinConfig_r     <= `RST_INTERRUPT_PIN_CONFIG;
        end else if (regWrite) begin
            case (regAddr)
                `OFS_PULSE_DENSITY_CONFIG: pulseDensityConfig_r     <= regWdata;
                `OFS_PDM_DIVIDER_CONTROL:  pdmDividerControl_r      <= regWdata;
                `OFS_DSD_DIVIDER_CONTROL:  dsdDividerControl_r      <= regWdata;
                `OFS_CLOCK_ERR_SRC_EN:     clockErrorSourceEnable_r <= regWdata;
                `OFS_CLOCK_ERR_TIMEOUTS:   clockErrorTimeouts_r     <= regWdata;
                `OFS_INTERRUPT_PIN_CONFIG: interruptPinConfig_r     <= regWdata;
                default: ;
            endcase
        end
    end

    // Register reads, unmapped offsets return zero
    always_comb begin
        case (regAddr)
            `OFS_CLOCK_ERR_STATUS:     regRdata_nxt = {7'h00, clockErrorStickyFlag_r};
            `OFS_PULSE_DENSITY_CONFIG: regRdata_nxt = pulseDensityConfig_r;
            `OFS_PDM_DIVIDER_CONTROL:  regRdata_nxt = pdmDividerControl_r;
            `OFS_DSD_DIVIDER_CONTROL:  regRdata_nxt = dsdDividerControl_r;
            `OFS_CLOCK_ERR_SRC_EN:     regRdata_nxt = clockErrorSourceEnable_r;
            `OFS_CLOCK_ERR_TIMEOUTS:   regRdata_nxt = clockErrorTimeouts_r;
            `OFS_INTERRUPT_PIN_CONFIG: regRdata_nxt = interruptPinConfig_r;
            default:                   regRdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            regRdata_r  <= 8'h00;
            regRvalid_r <= 1'b0;
        end else begin
            regRdata_r  <= regRead ? regRdata_nxt : 8'h00;
            regRvalid_r <= regRead;
        end
    end

    // Density input divider; held low and cleared while powered down
    always_ff @(posedge clk) begin
        if (srst || !densityDivPower) begin
            densityDivCount_r <= 8'h00;
            densityDivClk_r   <= 1'b0;
        end else if (densityDivCount_r == `DENSITY_DIV_HALF_PERIOD - 8'h01) begin
            densityDivCount_r <= 8'h00;
            densityDivClk_r   <= ~densityDivClk_r;
        end else begin
            densityDivCount_r <= densityDivCount_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            densityDivRunning_r   <= 1'b0;
            bitstreamDivPowered_r <= 1'b0;
        end else begin
            densityDivRunning_r   <= densityDivPower;
            bitstreamDivPowered_r <= bitstreamDivPower;
        end
    end

    // Pin drivers: enable follows direction bit
    always_ff @(posedge clk) begin
        if (srst) begin
            densityInputClockOe_r   <= 1'b0;
            densityInputClockOut_r  <= 1'b0;
            densityOutputClockOe_r  <= 1'b0;
            densityOutputClockOut_r <= 1'b0;
        end else begin
            densityInputClockOe_r   <= pdmInClkDir;
            densityInputClockOut_r  <= pdmInClkDir & densityDivClk_r;
            densityOutputClockOe_r  <= pdmOutClkDir;
            densityOutputClockOut_r <= pdmOutClkDir & densityDivClk_r;
        end
    end

    // PDM clock seen by the latch: own clock when driven, pin otherwise
    assign pdmClockLevel = pdmInClkDir ? densityInputClockOut_r : densityInputClockIn;
    assign pdmRise       = pdmClockLevel & ~pdmClockPrev_r;
    assign pdmFall       = ~pdmClockLevel & pdmClockPrev_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            pdmClockPrev_r <= 1'b0;
        end else begin
            pdmClockPrev_r <= pdmClockLevel;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pdmLatchedData_r <= 1'b0;
            pdmLatchValid_r  <= 1'b0;
        end else begin
            pdmLatchValid_r <= pdmLatchEdgeSel ? pdmFall : pdmRise;
            if (pdmLatchEdgeSel ? pdmFall : pdmRise) begin
                pdmLatchedData_r <= pdmData;
            end
        end
    end

    // Missing-clock detectors
    detector_if detBus [NUM_DET] ();
    logic [NUM_DET-1:0] detExpired;

    assign detBus[0].enable = detectorOneEnable;
    assign detBus[0].limit  = timeout_cycles(detectorOneTimeout);
    assign detBus[0].watchedLevel = detectorOneSource ? pdmClockLevel : serialAudioClock;
    assign detBus[1].enable = detectorTwoEnable;
    assign detBus[1].limit  = timeout_cycles(detectorTwoTimeout);

    // Reserved source watches nothing, so an enabled detector times out
    always_comb begin
        case (detectorTwoSource)
            SRC_DAC_MOD: detBus[1].watchedLevel = dacModClock;
            SRC_ADC_MOD: detBus[1].watchedLevel = adcModClock;
            SRC_PLL:     detBus[1].watchedLevel = pllClock;
            default:     detBus[1].watchedLevel = 1'b0;
        endcase
    end

    for (genvar gi = 0; gi < NUM_DET; gi++) begin : g_det
        missing_clock_detector u_det (
            .clk  (clk),
            .srst (srst),
            .dbus (detBus[gi])
        );
        assign detExpired[gi] = detBus[gi].expired;
    end

    assign anyExpired  = |detExpired;
    assign stickyClear = regWrite && (regAddr == `OFS_CLOCK_ERR_STATUS)
                         && regWdata[`BIT_CLOCK_ERR_STICKY];

    // Sticky flag: a new error wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            clockErrorStickyFlag_r <= 1'b0;
        end else if (anyExpired) begin
            clockErrorStickyFlag_r <= 1'b1;
        end else if (stickyClear) begin
            clockErrorStickyFlag_r <= 1'b0;
        end
    end

    // Shutdown holds until the host clears the error
    always_ff @(posedge clk) begin
        if (srst) begin
            clockErrorShutdown_r <= 1'b0;
        end else begin
            clockErrorShutdown_r <= anyExpired | (clockErrorStickyFlag_r & ~stickyClear);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dspMemReload_r <= 1'b0;
        end else begin
            dspMemReload_r <= faultRestart & dspMemReloadOnRestart;
        end
    end
endmodule : pdm_clock_and_missing_clock_detect
`default_nettype wire

// [src/pdm_clk_defs.svh]
// Register offsets, reset values, field positions and timing counts
`ifndef PDM_CLK_DEFS_SVH
`define PDM_CLK_DEFS_SVH

`define OFS_CLOCK_ERR_STATUS     8'h05
`define OFS_PULSE_DENSITY_CONFIG 8'h1c
`define OFS_PDM_DIVIDER_CONTROL  8'h1d
`define OFS_DSD_DIVIDER_CONTROL  8'h1e
`define OFS_CLOCK_ERR_SRC_EN     8'h21
`define OFS_CLOCK_ERR_TIMEOUTS   8'h22
`define OFS_INTERRUPT_PIN_CONFIG 8'h23

`define RST_PULSE_DENSITY_CONFIG 8'h00
`define RST_PDM_DIVIDER_CONTROL  8'h08
`define RST_DSD_DIVIDER_CONTROL  8'h08
`define RST_CLOCK_ERR_SRC_EN     8'h03
`define RST_CLOCK_ERR_TIMEOUTS   8'h3f
`define RST_INTERRUPT_PIN_CONFIG 8'h21

// Pulse density config
`define BIT_PDM_LATCH_EDGE_SEL 2
`define BIT_DENSITY_INPUT_CLOCK_DIR     1
`define BIT_DENSITY_OUTPUT_CLOCK_DIR    0
// Divider controls
`define BIT_DIV_POWER          7
// Clock error source / enable
`define BIT_DSP_MEM_RELOAD     7
`define BIT_DETECTOR_ONE_SRC   4
`define MSB_DETECTOR_TWO_SRC   3
`define LSB_DETECTOR_TWO_SRC   2
`define BIT_DETECTOR_ONE_EN    1
`define BIT_DETECTOR_TWO_EN    0
// Clock error timeouts
`define MSB_DETECTOR_ONE_TIME  5
`define LSB_DETECTOR_ONE_TIME  3
`define MSB_DETECTOR_TWO_TIME  2
`define LSB_DETECTOR_TWO_TIME  0
// Status
`define BIT_CLOCK_ERR_STICKY   0

`define CLK_MHZ 200
`define TIMEOUT_US_0 11000
`define TIMEOUT_US_1 22000
`define TIMEOUT_US_2 44000
`define TIMEOUT_US_3 87000
`define TIMEOUT_US_4 174000
`define TIMEOUT_US_5 350000
`define TIMEOUT_US_6 700000
`define TIMEOUT_US_7 1200000
`define US_TO_CYC(us) ((us) * `CLK_MHZ)

// Half period of the density input divider, in clk cycles
`define DENSITY_DIV_HALF_PERIOD 8'h08

`endif

// [src/pdm_clk_pkg.sv]
// Types shared by the clock control block and its detectors
package pdm_clk_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [2:0]  timeout_code_t;
    typedef logic [27:0] tick_count_t;
    typedef enum logic [1:0] {
        SRC_DAC_MOD,
        SRC_ADC_MOD,
        SRC_PLL,
        SRC_RESERVED
    } detector_two_src_t;
endpackage : pdm_clk_pkg

// [src/detector_if.sv]
// Carrier between the clock control top and one missing-clock detector
`timescale 1ns/1ps
`default_nettype none
interface detector_if;
    import pdm_clk_pkg::*;
    logic        enable;
    logic        watchedLevel;
    tick_count_t limit;
    logic        expired;
    modport ctrl (output enable, output watchedLevel, output limit, input expired);
    modport det  (input enable, input watchedLevel, input limit, output expired);
endinterface : detector_if
`default_nettype wire

// [src/missing_clock_detector.sv]
// Missing-clock detector: flags a watched clock that stops toggling
`timescale 1ns/1ps
`default_nettype none
module missing_clock_detector
    import pdm_clk_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    detector_if.det   dbus
);
    import pdm_clk_pkg::*;

    logic        prevLevel_r;
    tick_count_t count_r;
    logic        expired_r;
    logic        edgeSeen;

    assign edgeSeen   = dbus.watchedLevel ^ prevLevel_r;
    assign dbus.expired = expired_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            prevLevel_r <= 1'b0;
        end else begin
            prevLevel_r <= dbus.watchedLevel;
        end
    end

    // Counts on clk, so a stopped watched clock still lets time run out
    always_ff @(posedge clk) begin
        if (srst || !dbus.enable || edgeSeen) begin
            count_r <= '0;
        end else if (count_r != dbus.limit) begin
            count_r <= count_r + tick_count_t'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !dbus.enable) begin
            expired_r <= 1'b0;
        end else begin
            expired_r <= !edgeSeen && (count_r >= dbus.limit - tick_count_t'(1));
        end
    end
endmodule : missing_clock_detector
`default_nettype wire

// [tb/pdm_clock_source.sv]
// Far-side model: PDM pin clock, PDM data and the watched clocks
`timescale 1ns/1ps
`default_nettype none
module pdm_clock_source (
    input  wire logic       clk,
    input  wire logic [4:0] runMask,
    output var  logic       pdmClk,
    output wire logic       pdmDat,
    output var  logic [3:0] watched
);
    logic [1:0] phase_r   = 2'h0;
    logic [7:0] pattern_r = 8'h5a;
    initial begin
        pdmClk = 1'b0;
        watched = 4'h0;
    end
    // Stopped clocks hold their level, which is what a missing clock looks like
    always @(negedge clk) begin
        phase_r <= phase_r + 2'h1;
        pattern_r <= {pattern_r[6:0], pattern_r[7] ^ pattern_r[5] ^ ~pattern_r[0]};
        if (phase_r == 2'h3) begin
            pdmClk <= pdmClk ^ runMask[0];
            watched <= watched ^ runMask[4:1];
        end
    end
    assign pdmDat = pattern_r[0];
endmodule : pdm_clock_source
`default_nettype wire

// [tb/pdm_clk_asserts.sv]
// Port-level assertions for the clock control block
`timescale 1ns/1ps
`default_nettype none
module pdm_clk_asserts (
    input wire logic clk, srst, regWrite, regRead,
    input wire pdm_clk_pkg::reg_byte_t regAddr, regWdata, regRdata_r,
    input wire logic densityInputClockIn, densityInputClockOut_r, densityInputClockOe_r,
    input wire logic densityOutputClockOe_r, pdmData, pdmLatchedData_r, pdmLatchValid_r,
    input wire logic densityDivRunning_r, bitstreamDivPowered_r, faultRestart,
    input wire logic dspMemReload_r, clockErrorShutdown_r
);
    import pdm_clk_pkg::*;
    reg_byte_t  cfgShadow_r;
    reg_byte_t  errCfg_r;
    logic [3:0] wrAge_r;
    logic       clrReq;
    assign clrReq = regWrite && regAddr == 8'h05 && regWdata[0];
    always_ff @(posedge clk) begin
        if (srst) cfgShadow_r <= 8'h00;
        else if (regWrite && regAddr == 8'h1c) cfgShadow_r <= regWdata;
    end
    always_ff @(posedge clk) begin
        if (srst) errCfg_r <= 8'h03;
        else if (regWrite && regAddr == 8'h21) errCfg_r <= regWdata;
    end
    // Settling age after any write, so pin checks skip the update latency
    always_ff @(posedge clk) begin
        if (srst || regWrite) wrAge_r <= 4'h0;
        else if (wrAge_r != 4'hf) wrAge_r <= wrAge_r + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_divWrite(a);
        regWrite && regAddr == a ##1 !(regWrite && regAddr == a);
    endsequence
    sequence s_errDrop;
        clockErrorShutdown_r ##1 !clockErrorShutdown_r;
    endsequence
    a_latch_edge_data: assert property (pdmLatchValid_r && wrAge_r > 4'h1 && !$past(cfgShadow_r[1]) |->
        $past(densityInputClockIn) == !$past(cfgShadow_r[2]) && pdmLatchedData_r == $past(pdmData)
        && $past(densityInputClockIn, 2) == $past(cfgShadow_r[2])) else $error("latch edge or data wrong");
    a_in_pin_dir: assert property (wrAge_r > 4'h3 |-> densityInputClockOe_r == cfgShadow_r[1]
        && (cfgShadow_r[1] || !densityInputClockOut_r)) else $error("input pin direction wrong");
    a_out_pin_dir: assert property (wrAge_r > 4'h3 |-> densityOutputClockOe_r == cfgShadow_r[0])
        else $error("output pin direction wrong");
    a_pdm_divider_control_power: assert property (s_divWrite(8'h1d) |=> densityDivRunning_r == $past(regWdata[7], 2))
        else $error("pdm divider power wrong");
    a_dsd_divider_control_power: assert property (s_divWrite(8'h1e) |=> bitstreamDivPowered_r == $past(regWdata[7], 2))
        else $error("dsd divider power wrong");
    a_reload_policy: assert property (faultRestart |=> dspMemReload_r == $past(errCfg_r[7]))
        else $error("reload policy wrong");
    a_reload_cause: assert property (dspMemReload_r |-> $past(faultRestart))
        else $error("reload without restart");
    a_error_sticky: assert property (s_errDrop |-> $past(clrReq) || $past(clrReq, 2))
        else $error("shutdown dropped without clear");
    a_status_shows: assert property (regRead && regAddr == 8'h05 && clockErrorShutdown_r
        && !$past(clrReq) |=> regRdata_r == 8'h01) else $error("status flag not set");
    a_disabled_quiet: assert property ($rose(clockErrorShutdown_r) |->
        wrAge_r < 4'h4 || errCfg_r[1:0] != 2'h0) else $error("disabled detector fired");
endmodule : pdm_clk_asserts
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb;
    import pdm_clk_pkg::*;
    logic      clk, srst, regWrite, regRead, faultRestart, pinIn, pinOut, pinOe, outOe, outOut, dat, latD, latV;
    logic      divRun, dsdPow, reload, shutdown, rvalid;
    reg_byte_t regAddr, regWdata, rdata;
    logic [4:0] runMask;
    logic [3:0] watched;
    int        errors, samples_checked;
    localparam int STEP = 20;
    pdm_clock_source far (.clk(clk), .runMask(runMask), .pdmClk(pinIn), .pdmDat(dat), .watched(watched));
    pdm_clock_and_missing_clock_detect #(.TIMEOUT_CYC_0(STEP), .TIMEOUT_CYC_1(STEP*2), .TIMEOUT_CYC_2(STEP*3),
        .TIMEOUT_CYC_3(STEP*4), .TIMEOUT_CYC_4(STEP*5), .TIMEOUT_CYC_5(STEP*6), .TIMEOUT_CYC_6(STEP*7),
        .TIMEOUT_CYC_7(STEP*8)) uut (.clk(clk), .srst(srst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata_r(rdata), .regRvalid_r(rvalid),
        .densityInputClockIn(pinIn), .densityInputClockOut_r(pinOut), .densityInputClockOe_r(pinOe),
        .densityOutputClockIn(outOut), .densityOutputClockOut_r(outOut), .densityOutputClockOe_r(outOe),
        .pdmData(dat), .pdmLatchedData_r(latD), .pdmLatchValid_r(latV), .serialAudioClock(watched[0]),
        .dacModClock(watched[1]), .adcModClock(watched[2]), .pllClock(watched[3]),
        .densityDivRunning_r(divRun), .bitstreamDivPowered_r(dsdPow), .faultRestart(faultRestart),
        .dspMemReload_r(reload), .clockErrorShutdown_r(shutdown));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic wr(input reg_byte_t a, input reg_byte_t d);
        @(negedge clk);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge clk);
        regWrite = 1'b0;
    endtask : wr
    task automatic rd(input reg_byte_t a, input reg_byte_t exp);
        @(negedge clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRead = 1'b0;
        `CHK("read valid", 1'b1, rvalid)
        `CHK("read data", exp, rdata)
    endtask : rd
    task automatic sample64(output int lat, output int tog);
        logic prev;
        lat = 0;
        tog = 0;
        prev = pinOut;
        repeat (64) begin
            @(negedge clk);
            lat += int'(latV);
            tog += int'(pinOut != prev);
            prev = pinOut;
        end
    endtask : sample64
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic test_regs;
        reg_byte_t adr [8] = '{8'h1c, 8'h1d, 8'h1e, 8'h21, 8'h22, 8'h23, 8'h05, 8'h10};
        reg_byte_t rst [8] = '{8'h00, 8'h08, 8'h08, 8'h03, 8'h3f, 8'h21, 8'h00, 8'h00};
        foreach (adr[i]) rd(adr[i], rst[i]);
        wr(8'h23, 8'h5a);
        wr(8'h10, 8'hff);
        rd(8'h23, 8'h5a);
        rd(8'h10, 8'h00);
        wr(8'h23, 8'h21);
        $display("test regs done");
    endtask : test_regs
    task automatic test_latch;
        int lat, tog;
        for (int e = 0; e < 2; e++) begin
            wr(8'h1c, e[0] ? 8'h04 : 8'h00);
            repeat (4) @(negedge clk);
            sample64(lat, tog);
            `CHK("latch count", 8, lat)
            `CHK("pin toggles", 0, tog)
        end
        $display("test latch done");
    endtask : test_latch
    task automatic test_div;
        int lat, tog;
        runMask[0] = 1'b0;
        wr(8'h1c, 8'h03);
        wr(8'h1d, 8'h88);
        repeat (20) @(negedge clk);
        `CHK("in oe", 1'b1, pinOe)
        `CHK("out oe", 1'b1, outOe)
        `CHK("div run", 1'b1, divRun)
        sample64(lat, tog);
        `CHK("own toggles", 8, tog)
        `CHK("own latches", 4, lat)
        wr(8'h1d, 8'h08);
        repeat (4) @(negedge clk);
        sample64(lat, tog);
        `CHK("off toggles", 0, tog)
        `CHK("out off", 1'b0, outOut)
        `CHK("div off", 1'b0, divRun)
        for (int p = 0; p < 2; p++) begin
            wr(8'h1e, p[0] ? 8'h88 : 8'h08);
            repeat (3) @(negedge clk);
            `CHK("dsd power", p[0], dsdPow)
        end
        wr(8'h1c, 8'h00);
        runMask = 5'h1f;
        $display("test div done");
    endtask : test_div
    task automatic test_reload;
        for (int r = 0; r < 2; r++) begin
            wr(8'h21, r[0] ? 8'h80 : 8'h00);
            @(negedge clk);
            faultRestart = 1'b1;
            @(negedge clk);
            faultRestart = 1'b0;
            `CHK("reload pulse", r[0], reload)
            @(negedge clk);
            `CHK("reload end", 1'b0, reload)
        end
        $display("test reload done");
    endtask : test_reload
    task automatic test_quiet;
        wr(8'h22, 8'h00);
        wr(8'h21, 8'h03);
        repeat (200) @(negedge clk);
        `CHK("running clocks", 1'b0, shutdown)
        wr(8'h22, 8'h3e);
        wr(8'h21, 8'h05);
        runMask = 5'h1b;
        repeat (200) @(negedge clk);
        `CHK("unwatched stop", 1'b0, shutdown)
        wr(8'h21, 8'h00);
        runMask = 5'h00;
        repeat (400) @(negedge clk);
        `CHK("disabled", 1'b0, shutdown)
        runMask = 5'h1f;
        $display("test quiet done");
    endtask : test_quiet
    task automatic test_detect;
        reg_byte_t en [8] = '{8'h01, 8'h05, 8'h09, 8'h0d, 8'h02, 8'h12, 8'h03, 8'h03};
        reg_byte_t tm [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'h28, 8'h37, 8'h3e};
        logic [4:0] stop [8] = '{5'h04, 5'h08, 5'h10, 5'h00, 5'h02, 5'h01, 5'h02, 5'h02};
        int n, lim;
        for (int i = 0; i < 8; i++) begin
            lim = STEP * (i + 1);
            wr(8'h22, tm[i]);
            runMask = 5'h1f & ~stop[i];
            wr(8'h21, en[i]);
            n = 0;
            while (shutdown !== 1'b1 && n < 400) begin
                @(negedge clk);
                n++;
            end
            `CHK("expiry window", 1'b1, n >= lim - 2 && n <= lim + 4)
            rd(8'h05, 8'h01);
            runMask = 5'h1f;
            wr(8'h21, 8'h00);
            `CHK("held until clear", 1'b1, shutdown)
            wr(8'h05, 8'h01);
            repeat (3) @(negedge clk);
            `CHK("cleared", 1'b0, shutdown)
            rd(8'h05, 8'h00);
        end
        $display("test detect done");
    endtask : test_detect
    initial begin
        errors = 0;
        samples_checked = 0;
        {srst, regWrite, regRead, faultRestart} = 4'h8;
        regAddr = 8'h00;
        regWdata = 8'h00;
        runMask = 5'h1f;
        repeat (3) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        test_regs();
        test_latch();
        test_div();
        test_reload();
        test_quiet();
        test_detect();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule : tb
bind pdm_clock_and_missing_clock_detect pdm_clk_asserts chk (.clk(clk), .srst(srst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata_r(regRdata_r),
    .densityInputClockIn(densityInputClockIn), .densityInputClockOut_r(densityInputClockOut_r),
    .densityInputClockOe_r(densityInputClockOe_r), .densityOutputClockOe_r(densityOutputClockOe_r),
    .pdmData(pdmData), .pdmLatchedData_r(pdmLatchedData_r), .pdmLatchValid_r(pdmLatchValid_r),
    .densityDivRunning_r(densityDivRunning_r), .bitstreamDivPowered_r(bitstreamDivPowered_r),
    .faultRestart(faultRestart), .dspMemReload_r(dspMemReload_r), .clockErrorShutdown_r(clockErrorShutdown_r));
`default_nettype wire
